// File: src/bsd_lpf.sv
// First-order low-pass filter with a 13-bit coefficient.
`timescale 1ns/1ps
`default_nettype none
`include "bsd_regs.svh"
module bsd_lpf #(
    parameter int W = 16
) (
    input wire logic mclk, // Device clock.
    input wire logic resetn, // Asynchronous reset, active low.
    input wire logic en, // Filter runs while high.
    input wire logic sample_valid, // One-cycle sample strobe.
    input wire logic signed [W-1:0] sample, // New input sample.
    input wire logic [12:0] coef, // Coefficient, value coef/4096.
    output logic signed [W-1:0] y_out // Filtered output.
);
    import bsd_pkg::*;

    logic signed [W:0] diff;
    logic signed [W+14:0] prod;
    logic signed [W:0] step;

    // Up to a coefficient of 4096 the step never exceeds the difference.
    always_comb begin
        diff = {sample[W-1], sample} - {y_out[W-1], y_out};
        prod = diff * $signed({1'b0, coef});
        step = prod[W+`BSD_COEF_FRAC:`BSD_COEF_FRAC];
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            y_out <= '0;
        end else if (en && sample_valid) begin
            y_out <= y_out + step[W-1:0];
        end
    end
endmodule
`default_nettype wire

// File: src/bsd_pkg.sv
// Types shared by the battery-switch and diagnostic parameter block.
package bsd_pkg;
    typedef enum logic {BSD_SEL_LOW, BSD_SEL_HIGH} bsd_bat_t;
    typedef enum logic {BSD_RMS_IDLE, BSD_RMS_ROOT} bsd_rms_state_t;
    typedef logic [15:0] bsd_word_t;
endpackage

// File: src/bsd_regs.svh
// Offsets, field positions, reset values and counts of the battery-switch block.
`ifndef BSD_REGS_SVH
`define BSD_REGS_SVH

`define BSD_ADDR_W 8
`define BSD_OFS_HIGH_BAT_TH 8'h1f
`define BSD_OFS_LOW_BAT_TH 8'h20
`define BSD_OFS_SWITCH_COEF 8'h21
`define BSD_OFS_TRACK_COEF 8'h22
`define BSD_OFS_SPEEDUP_LO 8'h23
`define BSD_OFS_SPEEDUP_HI 8'h24
`define BSD_OFS_DIAG_AC 8'h35
`define BSD_OFS_DIAG_AC_COEF 8'h36

`define BSD_THR_MSB 14
`define BSD_THR_LSB 7
`define BSD_COEF_MSB 15
`define BSD_COEF_LSB 3
`define BSD_THR_MASK 16'h7f80
`define BSD_COEF_MASK 16'hfff8
`define BSD_RST_WORD 16'h0000

`define BSD_COEF_FRAC 12
`define BSD_ROOT_STEPS 16
`define BSD_MON_CHANNELS 4

`endif

// File: src/bsd_top.sv
// Battery switch thresholds, filter words, speedup threshold and ac rms.
`timescale 1ns/1ps
`default_nettype none
`include "bsd_regs.svh"
// Contract
// - High threshold is bits 14:7, 628 mV steps, selects high battery.
// - Low threshold is bits 14:7, 628 mV resolution, selects low battery.
// - Thresholds compare with filtered ring voltage plus overhead voltage.
// - Tracking enabled: ring voltage low-pass filtered with bits 15:3.
// - Switching ring voltage has own filter, coefficient bits 15:3.
// - Speedup threshold joins a high word and a low word.
// - Speedup mode enables when monitored value reaches joined threshold.
// - Diagnostic word holds filtered ac rms of monitor converter samples.
// - Monitor input for diagnostics chosen by diagnostic select setting.
// - The rms filter takes its coefficient from the ac coefficient word.
// - High threshold, both coefficients, high speedup, ac result reset zero.
module bsd_top #(
    parameter int MON_N = `BSD_MON_CHANNELS
) (
    input wire logic mclk, // Device clock, 20 MHz.
    input wire logic resetn, // Asynchronous reset, active low.
    input wire logic ram_wr, // One-cycle parameter write strobe.
    input wire logic ram_rd, // One-cycle parameter read strobe.
    input wire logic [7:0] ram_addr, // Parameter address.
    input wire logic [15:0] ram_wdata, // Write data.
    output logic [15:0] ram_rdata, // Read data, valid after ram_rd.
    input wire logic line_active, // Line is in normal active state.
    input wire logic tracking_enable, // Battery tracking enabled.
    input wire logic ring_valid, // Ring voltage sample strobe.
    input wire logic [15:0] ring_voltage, // Ring lead voltage magnitude.
    input wire logic [15:0] overhead_voltage, // Programmed overhead voltage.
    input wire logic [31:0] speedup_monitor, // Monitored speedup quantity.
    input wire logic mon_valid, // Monitor converter sample strobe.
    input wire logic [MON_N*16-1:0] mon_samples, // Monitor converter inputs.
    input wire logic [7:0] diag_input_select, // Diagnostic select setting.
    output bsd_pkg::bsd_bat_t battery_select, // Selected battery supply.
    output logic high_battery_supply, // High battery selected.
    output logic low_battery_supply, // Low battery selected.
    output logic [15:0] tracking_voltage, // Tracking-filtered ring voltage.
    output logic speedup_enable // Speedup mode enabled.
);
    import bsd_pkg::*;

    bsd_word_t high_battery_threshold;
    bsd_word_t low_battery_threshold;
    bsd_word_t switch_voltage_filter_coef;
    bsd_word_t tracking_filter_coef;
    bsd_word_t speedup_threshold_low;
    bsd_word_t speedup_threshold_high;
    bsd_word_t diag_ac_rms_result;
    bsd_word_t diag_ac_filter_coef;

    logic [31:0] speedup_threshold;
    logic [15:0] switch_voltage;
    logic [16:0] compare_sum;
    logic [16:0] high_limit;
    logic [16:0] low_limit;
    logic signed [15:0] mon_pick;
    logic signed [31:0] mon_square;
    logic [15:0] square_word;
    logic square_valid;
    logic mean_valid;
    logic signed [16:0] mean_square;
    bsd_rms_state_t rms_state;
    logic [3:0] root_bit;
    logic [15:0] root;
    logic [15:0] next_root;
    logic [31:0] radicand;
    logic [31:0] trial_square;
    logic root_done;
    logic [15:0] tracking_raw;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // Register writes; each word keeps only its documented field.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            high_battery_threshold <= `BSD_RST_WORD;
            low_battery_threshold <= `BSD_RST_WORD;
            switch_voltage_filter_coef <= `BSD_RST_WORD;
            tracking_filter_coef <= `BSD_RST_WORD;
            speedup_threshold_low <= `BSD_RST_WORD;
            speedup_threshold_high <= `BSD_RST_WORD;
            diag_ac_filter_coef <= `BSD_RST_WORD;
        end else if (ram_wr) begin
            if (hit(ram_addr, `BSD_OFS_HIGH_BAT_TH)) begin
                high_battery_threshold <= ram_wdata & `BSD_THR_MASK;
            end else if (hit(ram_addr, `BSD_OFS_LOW_BAT_TH)) begin
                low_battery_threshold <= ram_wdata & `BSD_THR_MASK;
            end else if (hit(ram_addr, `BSD_OFS_SWITCH_COEF)) begin
                switch_voltage_filter_coef <= ram_wdata & `BSD_COEF_MASK;
            end else if (hit(ram_addr, `BSD_OFS_TRACK_COEF)) begin
                tracking_filter_coef <= ram_wdata & `BSD_COEF_MASK;
            end else if (hit(ram_addr, `BSD_OFS_SPEEDUP_LO)) begin
                speedup_threshold_low <= ram_wdata;
            end else if (hit(ram_addr, `BSD_OFS_SPEEDUP_HI)) begin
                speedup_threshold_high <= ram_wdata;
            end else if (hit(ram_addr, `BSD_OFS_DIAG_AC_COEF)) begin
                diag_ac_filter_coef <= ram_wdata & `BSD_COEF_MASK;
            end
        end
    end

    // Read data is registered; unmapped addresses read zero.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ram_rdata <= '0;
        end else if (ram_rd) begin
            if (hit(ram_addr, `BSD_OFS_HIGH_BAT_TH)) begin
                ram_rdata <= high_battery_threshold;
            end else if (hit(ram_addr, `BSD_OFS_LOW_BAT_TH)) begin
                ram_rdata <= low_battery_threshold;
            end else if (hit(ram_addr, `BSD_OFS_SWITCH_COEF)) begin
                ram_rdata <= switch_voltage_filter_coef;
            end else if (hit(ram_addr, `BSD_OFS_TRACK_COEF)) begin
                ram_rdata <= tracking_filter_coef;
            end else if (hit(ram_addr, `BSD_OFS_SPEEDUP_LO)) begin
                ram_rdata <= speedup_threshold_low;
            end else if (hit(ram_addr, `BSD_OFS_SPEEDUP_HI)) begin
                ram_rdata <= speedup_threshold_high;
            end else if (hit(ram_addr, `BSD_OFS_DIAG_AC)) begin
                ram_rdata <= diag_ac_rms_result;
            end else if (hit(ram_addr, `BSD_OFS_DIAG_AC_COEF)) begin
                ram_rdata <= diag_ac_filter_coef;
            end else begin
                ram_rdata <= '0;
            end
        end
    end

    bsd_lpf #(.W(16)) u_switch_lpf (
        .mclk(mclk),
        .resetn(resetn),
        .en(1'b1),
        .sample_valid(ring_valid),
        .sample(ring_voltage),
        .coef(switch_voltage_filter_coef[`BSD_COEF_MSB:`BSD_COEF_LSB]),
        .y_out(switch_voltage)
    );

    bsd_lpf #(.W(16)) u_track_lpf (
        .mclk(mclk),
        .resetn(resetn),
        .en(tracking_enable),
        .sample_valid(ring_valid),
        .sample(ring_voltage),
        .coef(tracking_filter_coef[`BSD_COEF_MSB:`BSD_COEF_LSB]),
        .y_out(tracking_raw)
    );

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tracking_voltage <= '0;
        end else if (tracking_enable) begin
            tracking_voltage <= tracking_raw;
        end
    end

    // The sum stays within 17 bits; limits carry the 14:7 field in place.
    always_comb begin
        compare_sum = {1'b0, switch_voltage} + {1'b0, overhead_voltage};
        high_limit = {1'b0, high_battery_threshold & `BSD_THR_MASK};
        low_limit = {1'b0, low_battery_threshold & `BSD_THR_MASK};
    end

    // High wins when both limits are met; inside the band nothing changes.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            battery_select <= BSD_SEL_LOW;
        end else if (line_active) begin
            if (compare_sum >= high_limit) begin
                battery_select <= BSD_SEL_HIGH;
            end else if (compare_sum <= low_limit) begin
                battery_select <= BSD_SEL_LOW;
            end
        end
    end

    assign high_battery_supply = (battery_select == BSD_SEL_HIGH);
    assign low_battery_supply = (battery_select == BSD_SEL_LOW);

    assign speedup_threshold = {speedup_threshold_high, speedup_threshold_low};

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            speedup_enable <= 1'b0;
        end else begin
            speedup_enable <= (speedup_monitor >= speedup_threshold);
        end
    end

    // Monitor input pick and squaring stage.
    always_comb begin
        mon_pick = '0;
        for (int i = 0; i < MON_N; i++) begin
            if (diag_input_select == 8'(i)) begin
                mon_pick = mon_samples[i*16 +: 16];
            end
        end
        mon_square = mon_pick * mon_pick;
    end

    // The root starts one cycle after the filter, so it reads the new mean.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            square_word <= '0;
            square_valid <= 1'b0;
            mean_valid <= 1'b0;
        end else begin
            square_word <= mon_square[30:15];
            square_valid <= mon_valid;
            mean_valid <= square_valid;
        end
    end

    bsd_lpf #(.W(17)) u_rms_lpf (
        .mclk(mclk),
        .resetn(resetn),
        .en(1'b1),
        .sample_valid(square_valid),
        .sample({1'b0, square_word}),
        .coef(diag_ac_filter_coef[`BSD_COEF_MSB:`BSD_COEF_LSB]),
        .y_out(mean_square)
    );

    // Bit-serial square root of the filtered mean square, one bit per cycle.
    always_comb begin
        next_root = root | (16'h0001 << root_bit);
        trial_square = next_root * next_root;
        root_done = (rms_state == BSD_RMS_ROOT) && (root_bit == 4'h0);
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rms_state <= BSD_RMS_IDLE;
            root_bit <= '0;
            root <= '0;
            radicand <= '0;
        end else begin
            case (rms_state)
                BSD_RMS_IDLE: begin
                    if (mean_valid) begin
                        radicand <= {mean_square[15:0], 16'h0000} >> 1;
                        root <= '0;
                        root_bit <= 4'(`BSD_ROOT_STEPS - 1);
                        rms_state <= BSD_RMS_ROOT;
                    end
                end
                BSD_RMS_ROOT: begin
                    if (trial_square <= radicand) begin
                        root <= next_root;
                    end
                    root_bit <= root_bit - 4'h1;
                    if (root_bit == 4'h0) begin
                        rms_state <= BSD_RMS_IDLE;
                    end
                end
                default: rms_state <= BSD_RMS_IDLE;
            endcase
        end
    end

    // A finished result wins over a software write in the same cycle.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            diag_ac_rms_result <= `BSD_RST_WORD;
        end else if (root_done) begin
            if (trial_square <= radicand) begin
                diag_ac_rms_result <= next_root;
            end else begin
                diag_ac_rms_result <= root;
            end
        end else if (ram_wr && hit(ram_addr, `BSD_OFS_DIAG_AC)) begin
            diag_ac_rms_result <= ram_wdata;
        end
    end

    chk_high_select: assert property (@(posedge mclk) disable iff (!resetn)
        line_active && compare_sum >= high_limit |=> high_battery_supply)
        else $error("high battery not selected above high threshold");
    chk_low_select: assert property (@(posedge mclk) disable iff (!resetn)
        line_active && compare_sum < high_limit && compare_sum <= low_limit
        |=> low_battery_supply)
        else $error("low battery not selected below low threshold");
    chk_select_hold: assert property (@(posedge mclk) disable iff (!resetn)
        !line_active || (compare_sum < high_limit && compare_sum > low_limit)
        |=> $stable(battery_select))
        else $error("battery selection changed inside the band");
    chk_speedup_on: assert property (@(posedge mclk) disable iff (!resetn)
        speedup_monitor >= {speedup_threshold_high, speedup_threshold_low}
        |=> speedup_enable)
        else $error("speedup not enabled at threshold");
    chk_track_hold: assert property (@(posedge mclk) disable iff (!resetn)
        !tracking_enable |=> $stable(tracking_voltage))
        else $error("tracking voltage moved while tracking disabled");
    chk_rms_latency: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(rms_state == BSD_RMS_ROOT) |-> ##16 rms_state == BSD_RMS_IDLE)
        else $error("rms root did not finish in sixteen cycles");
    chk_high_store: assert property (@(posedge mclk) disable iff (!resetn)
        ram_wr && ram_addr == `BSD_OFS_HIGH_BAT_TH
        |=> high_battery_threshold == ($past(ram_wdata) & `BSD_THR_MASK))
        else $error("high threshold write not stored");
    chk_coef_store: assert property (@(posedge mclk) disable iff (!resetn)
        ram_wr && ram_addr == `BSD_OFS_SWITCH_COEF
        |=> switch_voltage_filter_coef == ($past(ram_wdata) & `BSD_COEF_MASK))
        else $error("switch coefficient write not stored");
    chk_reset_zero: assert property (@(posedge mclk)
        $rose(resetn) |-> high_battery_threshold == 16'h0000
        && tracking_filter_coef == 16'h0000 && diag_ac_rms_result == 16'h0000)
        else $error("words not zero after reset");

    cov_go_high: cover property (@(posedge mclk) disable iff (!resetn)
        $rose(high_battery_supply));
    cov_go_low: cover property (@(posedge mclk) disable iff (!resetn)
        $fell(high_battery_supply));
    cov_speedup: cover property (@(posedge mclk) disable iff (!resetn)
        $rose(speedup_enable));
    cov_rms_done: cover property (@(posedge mclk) disable iff (!resetn)
        root_done);
endmodule
`default_nettype wire

// File: verification/bsd_top_tb_top.sv
// Self-checking testbench for the battery-switch parameter block.
`timescale 1ns/1ps
`default_nettype none
`include "bsd_regs.svh"
module bsd_top_tb_top;
    import bsd_pkg::*;
    logic mclk, resetn, ram_wr, ram_rd, line_active, tracking_enable;
    logic ring_valid, mon_valid;
    logic [7:0] ram_addr, diag_input_select;
    logic [15:0] ram_wdata, ram_rdata, ring_voltage, overhead_voltage;
    logic [15:0] tracking_voltage, rd_word;
    logic [31:0] speedup_monitor;
    logic [63:0] mon_samples;
    bsd_bat_t battery_select;
    logic high_battery_supply, low_battery_supply, speedup_enable;
    int n_errors = 0;
    int compares = 0;
    logic [7:0] ofs [8] = '{`BSD_OFS_HIGH_BAT_TH, `BSD_OFS_LOW_BAT_TH,
        `BSD_OFS_SWITCH_COEF, `BSD_OFS_TRACK_COEF, `BSD_OFS_SPEEDUP_LO,
        `BSD_OFS_SPEEDUP_HI, `BSD_OFS_DIAG_AC, `BSD_OFS_DIAG_AC_COEF};
    logic [15:0] msk [8] = '{`BSD_THR_MASK, `BSD_THR_MASK, `BSD_COEF_MASK,
        `BSD_COEF_MASK, 16'hffff, 16'hffff, 16'hffff, `BSD_COEF_MASK};
    logic [31:0] mon_tab [5] = '{32'h0000_8000, 32'h0001_7fff,
        32'h0001_8000, 32'h0002_0000, 32'h0000_ffff};
    logic exp_tab [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

    bsd_top bsd_top_i (
        .mclk(mclk), .resetn(resetn), .ram_wr(ram_wr), .ram_rd(ram_rd),
        .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata),
        .line_active(line_active), .tracking_enable(tracking_enable),
        .ring_valid(ring_valid), .ring_voltage(ring_voltage),
        .overhead_voltage(overhead_voltage),
        .speedup_monitor(speedup_monitor), .mon_valid(mon_valid),
        .mon_samples(mon_samples), .diag_input_select(diag_input_select),
        .battery_select(battery_select),
        .high_battery_supply(high_battery_supply),
        .low_battery_supply(low_battery_supply),
        .tracking_voltage(tracking_voltage), .speedup_enable(speedup_enable)
    );

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic summarize();
        $display("errors %0d, comparisons %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t word got %h expected %h", $time, got,
                exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t flag got %b expected %b", $time, got,
                exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        ram_addr = a;
        ram_wdata = d;
        ram_wr = 1'b1;
        cyc(1);
        ram_wr = 1'b0;
        cyc(1);
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        ram_addr = a;
        ram_rd = 1'b1;
        cyc(1);
        ram_rd = 1'b0;
        d = ram_rdata;
        cyc(1);
    endtask

    // Filter, switching decision and register settle within three cycles.
    task automatic ring(input logic [15:0] v);
        ring_voltage = v;
        ring_valid = 1'b1;
        cyc(1);
        ring_valid = 1'b0;
        cyc(3);
    endtask

    task automatic bat_chk(input logic exp_high);
        chk_bit(high_battery_supply, exp_high);
        chk_bit(low_battery_supply, ~exp_high);
        chk_bit(battery_select, exp_high);
    endtask

    // One monitor sample, then enough cycles for square, filter and root.
    task automatic rms_run(input logic [7:0] sel, input logic [15:0] exp);
        diag_input_select = sel;
        mon_valid = 1'b1;
        cyc(1);
        mon_valid = 1'b0;
        cyc(25);
        rd(`BSD_OFS_DIAG_AC, rd_word);
        chk_word(rd_word, exp);
    endtask

    initial begin
        resetn = 1'b0;
        {ram_wr, ram_rd, line_active, tracking_enable} = 4'h0;
        {ring_valid, mon_valid} = 2'b00;
        ram_addr = 8'h00;
        ram_wdata = 16'h0000;
        ring_voltage = 16'h0000;
        overhead_voltage = 16'h0100;
        speedup_monitor = 32'h0000_0000;
        mon_samples = 64'h1000_4000_1000_1000;
        diag_input_select = 8'h00;
        repeat (5) @(posedge mclk);
        #1;
        chk_bit(low_battery_supply, 1'b1);
        chk_word(tracking_voltage, 16'h0000);
        resetn = 1'b1;
        cyc(1);
        for (int i = 0; i < 8; i++) begin
            rd(ofs[i], rd_word);
            chk_word(rd_word, 16'h0000);
            wr(ofs[i], 16'hffff);
            rd(ofs[i], rd_word);
            chk_word(rd_word, msk[i]);
        end
        wr(8'h40, 16'hffff);
        rd(8'h40, rd_word);
        chk_word(rd_word, 16'h0000);
        // Speedup threshold 0x0001_8000 joined from both words.
        wr(`BSD_OFS_SPEEDUP_HI, 16'h0001);
        wr(`BSD_OFS_SPEEDUP_LO, 16'h8000);
        for (int i = 0; i < 5; i++) begin
            speedup_monitor = mon_tab[i];
            cyc(2);
            chk_bit(speedup_enable, exp_tab[i]);
        end
        // Coefficient 0x8000 is unity gain, so one sample settles a filter.
        wr(`BSD_OFS_TRACK_COEF, 16'h8000);
        wr(`BSD_OFS_SWITCH_COEF, 16'h8000);
        tracking_enable = 1'b1;
        ring(16'h1234);
        chk_word(tracking_voltage, 16'h1234);
        wr(`BSD_OFS_TRACK_COEF, 16'h4000);
        ring(16'h0000);
        chk_word(tracking_voltage, 16'h091a);
        tracking_enable = 1'b0;
        ring(16'h2000);
        chk_word(tracking_voltage, 16'h091a);
        wr(`BSD_OFS_HIGH_BAT_TH, 16'h4000);
        wr(`BSD_OFS_LOW_BAT_TH, 16'h2000);
        ring(16'h3f00);
        bat_chk(1'b0);
        line_active = 1'b1;
        cyc(3);
        bat_chk(1'b1);
        ring(16'h3000);
        bat_chk(1'b1);
        ring(16'h1f00);
        bat_chk(1'b0);
        ring(16'h3eff);
        bat_chk(1'b0);
        overhead_voltage = 16'h0101;
        cyc(3);
        bat_chk(1'b1);
        wr(`BSD_OFS_DIAG_AC_COEF, 16'h8000);
        rms_run(8'h02, 16'h4000);
        rms_run(8'h00, 16'h1000);
        rms_run(8'h05, 16'h0000);
        wr(`BSD_OFS_DIAG_AC_COEF, 16'h0000);
        rms_run(8'h02, 16'h0000);
        summarize();
    end
endmodule
`default_nettype wire
